// ### design/flow_sensor_sleep_id_crc.sv
// I2C target command slice: sleep, identification, checksum, results
//
// How it works
// (RULE_01) Sleep command is taken only while idle, never during measurement.
// (RULE_02) Asleep, the general call reset is not acknowledged and does nothing.
// (RULE_03) Master enters sleep by writing 0x3677 after stopping measurement.
// (RULE_04) Own address with write bit wakes a sleeping device into idle.
// (RULE_05) The waking address byte is left unacknowledged.
// (RULE_06) Master polls the address until acknowledged, within 25 ms.
// (RULE_07) Identification needs write transfers 0x367C then 0xE102, separately.
// (RULE_08) Following read header returns six words, each with checksum.
// (RULE_09) Words go msb first: product number, then serial number.
// (RULE_10) Low byte of product number is revision; upper 24 bits product code.
// (RULE_11) Each checksum covers exactly the two preceding data bytes.
// (RULE_12) CRC-8 poly 0x31, preset 0xFF, no reflection, final XOR 0x00.
// (RULE_13) Flow is signed 16 bit, clamped to plus or minus 30000.
// (RULE_14) Host divides flow by 1200 to get ml/h.
// (RULE_15) Temperature is signed 16 bit; host divides by 200 for Celsius.
// (RULE_16) Stop 0x3FF9 returns to idle; busy up to 0.5 ms afterwards.
// (RULE_17) Master NACK then STOP ends a read; the data line is released.
// (RULE_18) Master rechecks each checksum and drops mismatched words.
`timescale 1ns/1ns

module flow_sensor_sleep_id_crc
  import flow_sensor_pkg::*;
#(
  parameter int STOP_CYCLES = `STOP_TIME_US * `CLK_MHZ,
  parameter int RESET_CYCLES = `RESET_TIME_US * `CLK_MHZ,
  parameter logic [23:0] PRODUCT_CODE = 24'h5a5a5a, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
  parameter logic [63:0] SERIAL = 64'h0123456789abcdef // Arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_meas_valid,
  output logic o_meas_ready,
  input wire logic [15:0] i_flow,
  input wire logic [15:0] i_temp,
  input wire logic i_air_in_line,
  input wire logic i_high_flow,
  input wire logic i_smoothing,
  output logic o_measuring,
  output logic o_asleep,
  output logic o_busy
);

  // ==========================================
  // Pin synchronisers and bus conditions
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_s1_reg <= i_scl;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= i_sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
    end
  end

  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_det = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

  // ==========================================
  // Measurement buffer
  logic [15:0] flow_clamped;
  logic [15:0] flags_word;
  logic buf_valid;
  logic [47:0] buf_data;
  logic pop_reg;
  logic [47:0] meas_reg;

  always_comb begin
    flow_clamped = i_flow;
    if ($signed(i_flow) > $signed(`FLOW_MAX)) begin
      flow_clamped = `FLOW_MAX; // RULE_13
    end else if ($signed(i_flow) < $signed(`FLOW_MIN)) begin
      flow_clamped = `FLOW_MIN; // RULE_13
    end
    flags_word = 16'h0000;
    flags_word[`FLAG_AIL_BIT] = i_air_in_line;
    flags_word[`FLAG_HIGH_BIT] = i_high_flow;
    flags_word[`FLAG_SMOOTH_BIT] = i_smoothing;
  end

  word_buffer #(.WIDTH(48)) u_buf (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(i_meas_valid),
    .o_in_ready(o_meas_ready),
    .i_in_data({flow_clamped, i_temp, flags_word}),
    .o_out_valid(buf_valid),
    .i_out_ready(pop_reg),
    .o_out_data(buf_data)
  );

  // ==========================================
  // Address and command decode
  i2c_state_t state_reg;
  mode_t mode_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, cmd_hi_reg;
  logic [1:0] byte_cnt_reg, rd_phase_reg;
  logic [2:0] rd_word_reg;
  logic gc_reg, rw_reg, src_id_reg, id_armed_reg, id_ready_reg;
  busy_t busy_cnt_reg;
  logic busy, addr_done, own_w, own_r, gc_w, rd_ok, accept, wake_evt;
  logic byte_done, cmd_evt, srst_evt;
  logic [15:0] cmd;

  assign busy = (busy_cnt_reg != '0);
  assign addr_done = (state_reg == ST_ADDR) && scl_fall && (bit_cnt_reg == 4'h8);
  assign own_w = (shift_reg[7:1] == `OWN_ADDR) && !shift_reg[0];
  assign own_r = (shift_reg[7:1] == `OWN_ADDR) && shift_reg[0];
  assign gc_w = (shift_reg[7:1] == `GC_ADDR) && !shift_reg[0];
  assign rd_ok = own_r && (((mode_reg == MODE_MEAS) && buf_valid) ||
                           ((mode_reg == MODE_IDLE) && id_ready_reg)); // RULE_08
  assign accept = addr_done && !busy && (mode_reg != MODE_SLEEP) &&
                  (own_w || gc_w || rd_ok); // RULE_02 RULE_05
  assign wake_evt = addr_done && !busy && (mode_reg == MODE_SLEEP) && own_w; // RULE_04
  assign byte_done = (state_reg == ST_WR) && scl_fall && (bit_cnt_reg == 4'h8);
  assign cmd = {cmd_hi_reg, shift_reg};
  assign cmd_evt = byte_done && !gc_reg && (byte_cnt_reg == 2'h1);
  assign srst_evt = byte_done && gc_reg && (byte_cnt_reg == 2'h0) && (shift_reg == `SRST_BYTE);

  // ==========================================
  // Read byte source
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  logic [31:0] product_num;

  assign product_num = {PRODUCT_CODE, REVISION}; // RULE_10

  always_comb begin
    rd_word = 16'h0000;
    if (src_id_reg) begin
      case (rd_word_reg) // RULE_09
        3'h0: rd_word = product_num[31:16];
        3'h1: rd_word = product_num[15:0];
        3'h2: rd_word = SERIAL[63:48];
        3'h3: rd_word = SERIAL[47:32];
        3'h4: rd_word = SERIAL[31:16];
        3'h5: rd_word = SERIAL[15:0];
        default: rd_word = 16'h0000;
      endcase
    end else begin
      case (rd_word_reg)
        3'h0: rd_word = meas_reg[47:32];
        3'h1: rd_word = meas_reg[31:16];
        3'h2: rd_word = meas_reg[15:0];
        default: rd_word = 16'h0000;
      endcase
    end
    case (rd_phase_reg)
      2'h0: rd_byte = rd_word[15:8];
      2'h1: rd_byte = rd_word[7:0];
      default: rd_byte = crc8_word(rd_word); // RULE_11 RULE_12
    endcase
    if (rd_word_reg > (src_id_reg ? `ID_LAST_WORD : `MEAS_LAST_WORD)) begin
      rd_byte = `FILL_BYTE;
    end
  end

  // ==========================================
  // Bus state machine
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      o_sda_oe <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      cmd_hi_reg <= 8'h00;
      byte_cnt_reg <= 2'h0;
      rd_word_reg <= 3'h0;
      rd_phase_reg <= 2'h0;
      gc_reg <= 1'b0;
      rw_reg <= 1'b0;
      src_id_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      o_sda_oe <= 1'b0; // RULE_17
    end else begin
      case (state_reg)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (addr_done) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= accept ? ST_ADDR_ACK : ST_SKIP; // RULE_05
            o_sda_oe <= accept;
            rw_reg <= shift_reg[0];
            gc_reg <= gc_w;
            byte_cnt_reg <= 2'h0;
            rd_word_reg <= 3'h0;
            rd_phase_reg <= 2'h0;
            src_id_reg <= (mode_reg == MODE_IDLE);
          end else if (byte_done) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WR_ACK;
            o_sda_oe <= (byte_cnt_reg != 2'h2);
            if (byte_cnt_reg == 2'h0) begin
              cmd_hi_reg <= shift_reg;
            end
            if (byte_cnt_reg != 2'h2) begin
              byte_cnt_reg <= byte_cnt_reg + 2'h1;
            end
          end
        end
        ST_ADDR_ACK, ST_RD_ACK: begin
          if (state_reg == ST_RD_ACK && scl_rise) begin
            if (sda_s2_reg) begin
              state_reg <= ST_SKIP; // RULE_17
            end else if (rd_phase_reg == `CRC_PHASE) begin
              rd_phase_reg <= 2'h0;
              if (rd_word_reg != 3'h7) begin
                rd_word_reg <= rd_word_reg + 3'h1;
              end
            end else begin
              rd_phase_reg <= rd_phase_reg + 2'h1;
            end
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= ST_RD;
              tx_reg <= rd_byte;
              o_sda_oe <= !rd_byte[7];
            end else begin
              state_reg <= ST_WR;
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            state_reg <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              o_sda_oe <= 1'b0;
              state_reg <= ST_RD_ACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              o_sda_oe <= !tx_reg[6];
            end
          end
        end
        ST_SKIP: o_sda_oe <= 1'b0;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Operating mode
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_reg <= MODE_IDLE;
      id_armed_reg <= 1'b0;
      id_ready_reg <= 1'b0;
    end else if (srst_evt) begin
      mode_reg <= MODE_IDLE;
      id_armed_reg <= 1'b0;
      id_ready_reg <= 1'b0;
    end else if (wake_evt) begin
      mode_reg <= MODE_IDLE; // RULE_04
    end else if (cmd_evt) begin
      if (mode_reg == MODE_MEAS) begin
        if (cmd == `CMD_STOP) begin
          mode_reg <= MODE_IDLE; // RULE_16
        end
      end else begin
        id_armed_reg <= (cmd == `CMD_ID1); // RULE_07
        id_ready_reg <= (cmd == `CMD_ID2) && id_armed_reg; // RULE_07
        if (cmd == `CMD_START) begin
          mode_reg <= MODE_MEAS;
        end else if (cmd == `CMD_SLEEP) begin
          mode_reg <= MODE_SLEEP; // RULE_01
        end
      end
    end
  end

  // ==========================================
  // Busy timer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busy_cnt_reg <= '0;
    end else if (srst_evt) begin
      busy_cnt_reg <= busy_t'(RESET_CYCLES);
    end else if (cmd_evt && (mode_reg == MODE_MEAS) && (cmd == `CMD_STOP)) begin
      busy_cnt_reg <= busy_t'(STOP_CYCLES); // RULE_16
    end else if (busy) begin
      busy_cnt_reg <= busy_cnt_reg - busy_t'(1);
    end
  end

  // ==========================================
  // Result latch
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pop_reg <= 1'b0;
      meas_reg <= '0;
    end else begin
      pop_reg <= accept && own_r && (mode_reg == MODE_MEAS);
      if (pop_reg) begin
        meas_reg <= buf_data; // RULE_15
      end
    end
  end

  assign o_sda_out = 1'b0;
  assign o_measuring = (mode_reg == MODE_MEAS);
  assign o_asleep = (mode_reg == MODE_SLEEP);
  assign o_busy = busy;

endmodule : flow_sensor_sleep_id_crc

// ### design/flow_sensor_cfg.svh
// Constants for the flow sensor command slice
`ifndef FLOW_SENSOR_CFG_SVH
`define FLOW_SENSOR_CFG_SVH

// ==========================================
// Bus addresses and commands
`define OWN_ADDR 7'h08
`define GC_ADDR 7'h00
`define SRST_BYTE 8'h06
`define CMD_START 16'h3608
`define CMD_STOP 16'h3ff9
`define CMD_SLEEP 16'h3677
`define CMD_ID1 16'h367c
`define CMD_ID2 16'he102

// ==========================================
// Read layout
`define ID_LAST_WORD 3'h5
`define MEAS_LAST_WORD 3'h2
`define CRC_PHASE 2'h2
`define FILL_BYTE 8'hff
`define FLAG_AIL_BIT 0
`define FLAG_HIGH_BIT 1
`define FLAG_SMOOTH_BIT 5
`define FLOW_MAX 16'h7530
`define FLOW_MIN 16'h8ad0

// ==========================================
// Checksum
`define CRC_POLY 8'h31
`define CRC_INIT 8'hff
`define CRC_XOR 8'h00

// ==========================================
// Timing
`define CLK_MHZ 100
`define STOP_TIME_US 500
`define RESET_TIME_US 25000

`endif

// ### design/flow_sensor_pkg.sv
// Types and checksum function for the flow sensor command slice
`include "flow_sensor_cfg.svh"

package flow_sensor_pkg;

  // ==========================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD = 3'b101,
    ST_RD_ACK = 3'b110,
    ST_SKIP = 3'b111
  } i2c_state_t;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_MEAS = 2'b01,
    MODE_SLEEP = 2'b10
  } mode_t;

  typedef logic [21:0] busy_t;

  // ==========================================
  // CRC-8 over one word, msb first
  function automatic logic [7:0] crc8_word(input logic [15:0] word);
    logic [7:0] crc;
    crc = `CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc[7] ^ word[i]) begin
        crc = {crc[6:0], 1'b0} ^ `CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    return crc ^ `CRC_XOR;
  endfunction : crc8_word

endpackage : flow_sensor_pkg

// ### design/word_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns

module word_buffer #(
  parameter int WIDTH = 48
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  logic [WIDTH-1:0] data0_reg;
  logic [WIDTH-1:0] data1_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data = data0_reg;
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      count_reg <= 2'h0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 2'h1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 2'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      data0_reg <= '0;
      data1_reg <= '0;
    end else if (push && !pop) begin
      if (count_reg == 2'h0) begin
        data0_reg <= i_in_data;
      end else begin
        data1_reg <= i_in_data;
      end
    end else if (pop && !push) begin
      data0_reg <= data1_reg;
    end else if (pop && push) begin
      if (count_reg == 2'h1) begin
        data0_reg <= i_in_data;
      end else begin
        data0_reg <= data1_reg;
        data1_reg <= i_in_data;
      end
    end
  end

endmodule : word_buffer

// ### dv/fs_port_chk.sv
// Port checker for the flow sensor command slice
`timescale 1ns/1ns

// ==========================================
// Checker
module fs_port_chk
  import flow_sensor_pkg::*;
#(
  parameter int STOP_CYCLES = 20,
  parameter int RESET_CYCLES = 50
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_meas_valid,
  input wire logic o_meas_ready,
  input wire logic [15:0] i_flow,
  input wire logic [15:0] i_temp,
  input wire logic i_air_in_line,
  input wire logic i_high_flow,
  input wire logic i_smoothing,
  input wire logic o_measuring,
  input wire logic o_asleep,
  input wire logic o_busy
);
  busy_t busy_cnt;
  logic [7:0] sleep_cnt;
  logic [5:0] hi_cnt;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_busy) begin
      busy_cnt <= '0;
    end else begin
      busy_cnt <= busy_cnt + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !o_asleep) begin
      sleep_cnt <= '0;
    end else if (sleep_cnt != 8'hff) begin
      sleep_cnt <= sleep_cnt + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_scl) begin
      hi_cnt <= '0;
    end else if (hi_cnt != 6'h3f) begin
      hi_cnt <= hi_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  mode_excl_a: assert property (!(o_measuring && o_asleep))
    else $error("measuring and asleep together");
  sleep_entry_a: assert property ($rose(o_asleep) |-> !$past(o_measuring))
    else $error("sleep entered from measurement");
  sleep_quiet_a: assert property (sleep_cnt == 8'hff |-> !o_sda_oe)
    else $error("data line driven while asleep");
  wake_idle_a: assert property ($fell(o_asleep) |-> !o_measuring && !o_busy)
    else $error("wake did not land in idle");
  busy_len_a: assert property ($fell(o_busy) |->
    (busy_cnt + 1 >= STOP_CYCLES && busy_cnt <= STOP_CYCLES + 1) ||
    (busy_cnt + 1 >= RESET_CYCLES && busy_cnt <= RESET_CYCLES + 1))
    else $error("busy time wrong");
  busy_nack_a: assert property (busy_cnt > 40 |-> !o_sda_oe)
    else $error("acknowledge while busy");
  stop_idle_a: assert property ($rose(o_busy) |-> ##[0:2] (!o_measuring && !o_asleep))
    else $error("stop did not reach idle");
  ready_fall_a: assert property ($fell(o_meas_ready) |-> $past(i_meas_valid))
    else $error("buffer filled without a push");
  oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
    else $error("data line changed with clock high");
  bus_free_a: assert property (hi_cnt > 6'd30 |-> !o_sda_oe)
    else $error("data line held on idle bus");

  sleep_c: cover property ($rose(o_asleep));
  wake_c: cover property ($fell(o_asleep));
  busy_c: cover property ($fell(o_busy));
  full_c: cover property ($fell(o_meas_ready));
endmodule : fs_port_chk

bind flow_sensor_sleep_id_crc fs_port_chk #(
  .STOP_CYCLES(STOP_CYCLES),
  .RESET_CYCLES(RESET_CYCLES)
) u_chk (.i_core_clk, .i_rst, .i_scl, .i_sda_in, .o_sda_out, .o_sda_oe, .i_meas_valid,
  .o_meas_ready, .i_flow, .i_temp, .i_air_in_line, .i_high_flow, .i_smoothing,
  .o_measuring, .o_asleep, .o_busy);

// ### dv/i2c_master_model.sv
// Bus master model driving clock and open-drain data
`timescale 1ns/1ns

// ==========================================
// Master
module i2c_master_model (
  input wire logic i_core_clk,
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : wt
  task automatic bit_x(input logic b, output logic s);
    wt(5);
    o_sda_oe = !b;
    wt(5);
    o_scl = 1'b1;
    wt(10);
    s = i_sda;
    o_scl = 1'b0;
  endtask : bit_x
  task automatic start();
    wt(5);
    o_sda_oe = 1'b0;
    wt(5);
    o_scl = 1'b1;
    wt(10);
    o_sda_oe = 1'b1;
    wt(10);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    wt(5);
    o_sda_oe = 1'b1;
    wt(5);
    o_scl = 1'b1;
    wt(10);
    o_sda_oe = 1'b0;
    wt(10);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
    end
    bit_x(1'b1, s);
    ack = !s;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, s);
  endtask : rbyte
endmodule : i2c_master_model

// ### dv/testbench.sv
// Self-checking bench for the flow sensor command slice
`timescale 1ns/1ns
`include "flow_sensor_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module testbench;
  localparam logic [23:0] PCODE = 24'h3c3c3c; // Arbitrary value
  localparam logic [7:0] REV = 8'h7e; // Arbitrary value
  localparam logic [63:0] SER = 64'hfedcba9876543210; // Arbitrary value
  localparam int STOP_N = 400;
  localparam int RST_N = 500;
  localparam logic [7:0] AW = {`OWN_ADDR, 1'b0};
  localparam logic [7:0] AR = {`OWN_ADDR, 1'b1};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mval = 1'b0;
  logic [15:0] flow = 16'h0000;
  logic [15:0] temp = 16'h0000;
  logic f_air = 1'b0;
  logic f_high = 1'b0;
  logic f_smooth = 1'b0;
  logic scl, m_oe, sda, dut_oe, dut_out, mready, measuring, asleep, busy;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 clk = !clk;
  assign sda = !(dut_oe || m_oe);

  flow_sensor_sleep_id_crc #(.STOP_CYCLES(STOP_N), .RESET_CYCLES(RST_N), .PRODUCT_CODE(PCODE),
    .REVISION(REV), .SERIAL(SER)) DUT (.i_core_clk(clk), .i_rst(rst), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(dut_out), .o_sda_oe(dut_oe), .i_meas_valid(mval),
    .o_meas_ready(mready), .i_flow(flow), .i_temp(temp), .i_air_in_line(f_air),
    .i_high_flow(f_high), .i_smoothing(f_smooth), .o_measuring(measuring),
    .o_asleep(asleep), .o_busy(busy));
  i2c_master_model mst (.i_core_clk(clk), .o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));

  // ==========================================
  // Helpers
  function automatic logic [7:0] crc_ref(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_ref
  task automatic hdr(input logic [7:0] b, output logic a);
    mst.start();
    mst.wbyte(b, a);
  endtask : hdr
  task automatic wr(input logic [15:0] c, output logic a);
    logic x;
    hdr(AW, a);
    mst.wbyte(c[15:8], x);
    mst.wbyte(c[7:0], x);
    mst.stop();
  endtask : wr
  task automatic rword(input logic last, output logic [15:0] w, output logic [7:0] c);
    mst.rbyte(1'b0, w[15:8]);
    mst.rbyte(1'b0, w[7:0]);
    mst.rbyte(last, c);
  endtask : rword

  // ==========================================
  // Scenarios
  task automatic t_ident();
    logic a;
    logic [15:0] w;
    logic [7:0] c;
    logic [95:0] id;
    id = {PCODE, REV, SER};
    `CHK("crc_ref", 8'h92, crc_ref(16'hbeef))
    wr(`CMD_ID1, a);
    `CHK("id1_ack", 1'b1, a)
    wr(`CMD_ID2, a);
    hdr(AR, a);
    `CHK("id_rd_ack", 1'b1, a)
    for (int i = 0; i < 6; i++) begin
      rword(i == 5, w, c);
      `CHK("id_word", id[95-16*i -: 16], w)
      `CHK("id_crc", crc_ref(w), c)
      if (i == 1) `CHK("revision", REV, w[7:0])
    end
    mst.stop();
    hdr(AR, a);
    mst.rbyte(1'b1, c);
    mst.stop();
    `CHK("abort_byte", PCODE[23:16], c)
    `CHK("sda_free", 1'b0, dut_oe)
    `CHK("sda_low_val", 1'b0, dut_out)
  endtask : t_ident

  task automatic t_meas();
    logic a;
    logic [15:0] w;
    logic [7:0] c;
    logic [15:0] ex [6];
    ex = '{16'h8ad0, 16'hfc18, 16'h0021, 16'h7530, 16'h1388, 16'h0002};
    wr(`CMD_START, a);
    hdr(AR, a);
    mst.stop();
    `CHK("empty_nack", 1'b0, a)
    @(negedge clk);
    {mval, flow, temp, f_air, f_smooth} = {1'b1, 16'h8000, 16'hfc18, 2'b11};
    @(negedge clk);
    {flow, temp, f_air, f_high, f_smooth} = {16'h7fff, 16'h1388, 3'b010};
    @(negedge clk);
    flow = 16'h0000;
    `CHK("full", 1'b0, mready)
    @(negedge clk);
    mval = 1'b0;
    wr(`CMD_SLEEP, a);
    `CHK("no_sleep_meas", 1'b0, asleep)
    for (int k = 0; k < 2; k++) begin
      hdr(AR, a);
      for (int j = 0; j < 3; j++) begin
        rword(j == 2, w, c);
        `CHK("meas_word", ex[3*k+j], w)
        `CHK("meas_crc", crc_ref(w), c)
        if (j == 0) `CHK("flow_mlh", (k == 0) ? -25 : 25, $signed(w) / 1200)
        if (j == 1) `CHK("temp_c", (k == 0) ? -5 : 25, $signed(w) / 200)
      end
      mst.stop();
    end
    wr(`CMD_STOP, a);
    `CHK("busy", 1'b1, busy)
    `CHK("idle", 1'b0, measuring)
    hdr(AW, a);
    mst.stop();
    `CHK("busy_nack", 1'b0, a)
    for (int n = 0; n < STOP_N && busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    `CHK("busy_end", 1'b0, busy)
  endtask : t_meas

  task automatic t_sleep();
    logic a;
    logic x;
    wr(`CMD_SLEEP, a);
    `CHK("asleep", 1'b1, asleep)
    mst.wt(300);
    hdr({`GC_ADDR, 1'b0}, a);
    mst.wbyte(`SRST_BYTE, x);
    mst.stop();
    `CHK("gc_nack", 1'b0, a)
    `CHK("gc_no_rst", 1'b0, busy)
    hdr(AR, a);
    mst.stop();
    `CHK("rd_sleep_nack", 1'b0, a)
    `CHK("rd_no_wake", 1'b1, asleep)
    hdr(AW, a);
    mst.stop();
    `CHK("wake_nack", 1'b0, a)
    `CHK("woken", 1'b0, asleep)
    a = 1'b0;
    for (int n = 0; n < 8 && a !== 1'b1; n++) begin
      hdr(AW, a);
      mst.stop();
    end
    `CHK("poll_ack", 1'b1, a)
  endtask : t_sleep

  task automatic t_srst();
    logic a;
    logic x;
    wr(`CMD_START, a);
    hdr({`GC_ADDR, 1'b0}, a);
    mst.wbyte(`SRST_BYTE, x);
    mst.stop();
    `CHK("gc_ack", 1'b1, a)
    `CHK("srst_ack", 1'b1, x)
    `CHK("srst_idle", 1'b0, measuring)
    `CHK("srst_busy", 1'b1, busy)
    hdr(AW, a);
    mst.stop();
    `CHK("srst_nack", 1'b0, a)
    for (int n = 0; n < RST_N && busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    `CHK("srst_end", 1'b0, busy)
  endtask : t_srst

  // ==========================================
  // Run control
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    t_ident();
    t_meas();
    t_sleep();
    t_srst();
    give_verdict();
  end
endmodule : testbench
